// file: inc/edp_pkg.sv
// package for the external debug event pin block: map, fields, reset values
package edp_pkg;

  localparam int          NUM_UNITS     = 4;              // breakpoint/watchpoint units
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;

  // register byte addresses
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;          // debug_control_reg
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;          // debug_status_reg, clear on read
  localparam logic [7:0]  ADDR_MASK     = 8'h08;          // interrupt mask
  localparam logic [7:0]  ADDR_UNIT0    = 8'h10;          // first unit control register
  localparam logic [7:0]  ADDR_STEP     = 8'h04;          // one word per unit

  // field encodings
  localparam logic [1:0]  EIC_BREAK     = 2'h1;           // event input forces a breakpoint
  localparam logic [1:0]  EOS_ENTRY     = 2'h1;           // pulse on debug entry
  localparam logic [1:0]  EOS_HITS      = 2'h2;           // show unit hit status
  localparam int          UNIT_EOC_BIT  = 0;              // event-output enable in unit control
  localparam int          SEL_LANE0     = 0;              // all fields live in byte lane 0

  // control register layout: [3:2] event_out_select, [1:0] event_in_control
  typedef struct packed {
    logic [1:0] event_out_select;
    logic [1:0] event_in_control;
  } edp_ctrl_t;

  // status / mask layout: [2] unit hit, [1] debug entry, [0] external_break_flag
  typedef struct packed {
    logic       unit_hit;
    logic       dbg_entry;
    logic       external_break_flag;
  } edp_status_t;

  localparam int          CTRL_W        = $bits(edp_ctrl_t);
  localparam int          STAT_W        = $bits(edp_status_t);
  localparam edp_ctrl_t   CTRL_RST      = '{event_out_select: 2'h0, event_in_control: 2'h0};
  localparam edp_status_t STAT_RST      = '{unit_hit: 1'h0, dbg_entry: 1'h0, external_break_flag: 1'h0};
  localparam logic [NUM_UNITS-1:0] EOC_RST = 4'h0;
  localparam logic [DATA_W-1:0]    DATA_ZERO = 32'h0000_0000;

endpackage : edp_pkg

// file: design/edp_top.sv
// external debug event pins: event input breakpoint, event output pin, wishbone registers
//
// Summary of operation
// - event_in_control 01: input falling edge halts CPU
// - external breakpoint sets external_break_flag in status
// - select 01: output low one clock per entry
// - enabled units show hit status on output
// - hit status shown only while select is 10
module edp_top
  import edp_pkg::*;
(
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [ADDR_W-1:0]    wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [DATA_W-1:0]    wb_dat_i,
  output logic      [DATA_W-1:0]    wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 ext_event_in_i,
  input  wire logic                 debug_mode_i,
  input  wire logic [NUM_UNITS-1:0] unit_hit_i,
  output logic                      ext_event_out_o,
  output logic                      halt_req_o,
  output logic                      irq_o
);

  edp_ctrl_t             debug_control_reg;
  edp_ctrl_t             next_debug_control_reg;
  edp_status_t           debug_status_reg;
  edp_status_t           next_debug_status_reg;
  edp_status_t           irq_mask;
  edp_status_t           next_irq_mask;
  logic [NUM_UNITS-1:0]  eoc_en;
  logic [NUM_UNITS-1:0]  next_eoc_en;
  logic [NUM_UNITS-1:0]  unit_sel;
  logic [DATA_W-1:0]     next_wb_dat_o;
  logic                  next_wb_ack_o;
  logic                  evt_sync1;
  logic                  evt_sync2;
  logic                  evt_prev;
  logic                  dbg_prev;
  logic                  next_ext_event_out_o;
  logic                  next_halt_req_o;
  logic                  next_irq_o;
  logic                  access;
  logic                  commit;
  logic                  wr_lane0;
  logic                  evt_fall;
  logic                  dbg_rise;
  logic                  any_hit;
  edp_status_t           set_bits;
  edp_status_t           clr_bits;

  // bus handshake: answer one edge after the request, commit at the edge ack is sampled
  assign access   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign commit   = wb_cyc_i && wb_stb_i && wb_ack_o;
  assign wr_lane0 = commit && wb_we_i && wb_sel_i[SEL_LANE0];

  // one select line per unit control register
  genvar gi;
  generate
    for (gi = 0; gi < NUM_UNITS; gi++)
    begin : g_unit
      assign unit_sel[gi] = (wb_adr_i == ADDR_UNIT0 + ADDR_W'(gi) * ADDR_STEP);
      always_comb
      begin
        next_eoc_en[gi] = eoc_en[gi];
        if (wr_lane0 && unit_sel[gi])
        begin
          next_eoc_en[gi] = wb_dat_i[UNIT_EOC_BIT];
        end
      end
    end
  endgenerate

  // event detection; only the second synchroniser stage feeds the edge detector
  assign evt_fall = evt_prev && !evt_sync2;
  assign dbg_rise = debug_mode_i && !dbg_prev;
  assign any_hit  = |(unit_hit_i & eoc_en);

  // next state of registers, flags and pins
  always_comb
  begin
    next_debug_control_reg = debug_control_reg;
    next_irq_mask          = irq_mask;
    next_wb_dat_o          = DATA_ZERO;
    next_wb_ack_o          = access;
    set_bits               = STAT_RST;
    clr_bits               = STAT_RST;
    if (wr_lane0 && wb_adr_i == ADDR_CTRL)
    begin
      next_debug_control_reg = edp_ctrl_t'(wb_dat_i[CTRL_W-1:0]);
    end
    if (wr_lane0 && wb_adr_i == ADDR_MASK)
    begin
      next_irq_mask = edp_status_t'(wb_dat_i[STAT_W-1:0]);
    end
    // read data is a snapshot; unmapped addresses read zero and ignore writes
    if (access && !wb_we_i)
    begin
      if (wb_adr_i == ADDR_CTRL)
      begin
        next_wb_dat_o[CTRL_W-1:0] = debug_control_reg;
      end
      else if (wb_adr_i == ADDR_STATUS)
      begin
        next_wb_dat_o[STAT_W-1:0] = debug_status_reg;
      end
      else if (wb_adr_i == ADDR_MASK)
      begin
        next_wb_dat_o[STAT_W-1:0] = irq_mask;
      end
      else
      begin
        for (int i = 0; i < NUM_UNITS; i++)
        begin
          if (unit_sel[i])
          begin
            next_wb_dat_o[UNIT_EOC_BIT] = eoc_en[i];
          end
        end
      end
    end
    // clear only what the reader was shown, so later events are never lost
    if (commit && !wb_we_i && wb_adr_i == ADDR_STATUS)
    begin
      clr_bits = edp_status_t'(wb_dat_o[STAT_W-1:0]);
    end
    next_halt_req_o = evt_fall && (debug_control_reg.event_in_control == EIC_BREAK);
    set_bits.external_break_flag = next_halt_req_o;
    set_bits.dbg_entry           = dbg_rise;
    set_bits.unit_hit            = any_hit;
    // set wins over the clear in the same cycle
    next_debug_status_reg = (debug_status_reg & ~clr_bits) | set_bits;
    next_irq_o            = |(next_debug_status_reg & next_irq_mask);
    // output pin is active low; idle high in every other select value
    case (debug_control_reg.event_out_select)
      EOS_ENTRY: next_ext_event_out_o = !dbg_rise;
      EOS_HITS:  next_ext_event_out_o = !any_hit;
      default:   next_ext_event_out_o = 1'b1;
    endcase
  end

  // register stage
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      debug_control_reg <= CTRL_RST;
      debug_status_reg  <= STAT_RST;
      irq_mask          <= STAT_RST;
      eoc_en            <= EOC_RST;
      wb_dat_o          <= DATA_ZERO;
      wb_ack_o          <= 1'b0;
      evt_sync1         <= 1'b1;
      evt_sync2         <= 1'b1;
      evt_prev          <= 1'b1;
      dbg_prev          <= 1'b0;
      ext_event_out_o   <= 1'b1;
      halt_req_o        <= 1'b0;
      irq_o             <= 1'b0;
    end
    else
    begin
      debug_control_reg <= next_debug_control_reg;
      debug_status_reg  <= next_debug_status_reg;
      irq_mask          <= next_irq_mask;
      eoc_en            <= next_eoc_en;
      wb_dat_o          <= next_wb_dat_o;
      wb_ack_o          <= next_wb_ack_o;
      evt_sync1         <= ext_event_in_i;
      evt_sync2         <= evt_sync1;
      evt_prev          <= evt_sync2;
      dbg_prev          <= debug_mode_i;
      ext_event_out_o   <= next_ext_event_out_o;
      halt_req_o        <= next_halt_req_o;
      irq_o             <= next_irq_o;
    end
  end

  // checks on the block's own outputs
  AST_BREAK_HALT: assert property (@(posedge mclk_i) disable iff (rst_i)
    (evt_prev && !evt_sync2 && debug_control_reg.event_in_control == EIC_BREAK) |=> halt_req_o)
    else $error("falling event input did not raise halt request");

  AST_EXB_FLAG: assert property (@(posedge mclk_i) disable iff (rst_i)
    halt_req_o |-> debug_status_reg.external_break_flag)
    else $error("halt request without external break flag");

  AST_ENTRY_PULSE: assert property (@(posedge mclk_i) disable iff (rst_i)
    (debug_control_reg.event_out_select == EOS_ENTRY && $rose(debug_mode_i))
      |=> !ext_event_out_o ##1 (ext_event_out_o || debug_control_reg.event_out_select != EOS_ENTRY))
    else $error("debug entry pulse not exactly one cycle low");

  AST_HIT_SHOW: assert property (@(posedge mclk_i) disable iff (rst_i)
    (debug_control_reg.event_out_select == EOS_HITS && |(unit_hit_i & eoc_en)) |=> !ext_event_out_o)
    else $error("enabled unit hit not shown on output");

  AST_HIT_GATED: assert property (@(posedge mclk_i) disable iff (rst_i)
    (debug_control_reg.event_out_select != EOS_HITS
      && !(debug_control_reg.event_out_select == EOS_ENTRY && $rose(debug_mode_i))) |=> ext_event_out_o)
    else $error("output pin low outside its select mode");

  AST_BREAK_OFF: assert property (@(posedge mclk_i) disable iff (rst_i)
    (debug_control_reg.event_in_control != EIC_BREAK) |=> !halt_req_o)
    else $error("halt request while event input is disabled");

  AST_ACK_ONE: assert property (@(posedge mclk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle after request");

  // irq is registered from the next values, so it must track the registered status and mask exactly
  AST_IRQ: assert property (@(posedge mclk_i) disable iff (rst_i)
    irq_o == |(debug_status_reg & irq_mask))
    else $error("interrupt does not match unmasked status bits");

  COV_BREAK: cover property (@(posedge mclk_i) disable iff (rst_i) halt_req_o);
  COV_ENTRY: cover property (@(posedge mclk_i) disable iff (rst_i)
    debug_control_reg.event_out_select == EOS_ENTRY && !ext_event_out_o);
  COV_HIT:   cover property (@(posedge mclk_i) disable iff (rst_i)
    debug_control_reg.event_out_select == EOS_HITS && !ext_event_out_o);
  COV_IRQ:   cover property (@(posedge mclk_i) disable iff (rst_i) $rose(irq_o));

endmodule : edp_top

// file: tb/edp_equip.sv
// trigger equipment model that pulls the event input pin low on request
module edp_equip
(
  input  wire logic mclk_i,
  input  wire logic fire_i,
  output logic      ext_event_in_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] hold_cnt = 2'h0;

  // hold low three cycles: one is the minimum, the synchroniser wants margin
  always @(posedge mclk_i)
  begin
    hold_cnt <= fire_i ? 2'h3 : ((hold_cnt != 2'h0) ? hold_cnt - 2'h1 : 2'h0);
  end

  // a released pin rests high through its pull-up
  assign ext_event_in_o = (hold_cnt == 2'h0);
endmodule : edp_equip

// file: tb/ext_debug_event_pins_bench.sv
// self-checking bench for the external debug event pins
module ext_debug_event_pins_bench;
  import edp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 mclk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, fire = 1'b0, dbg = 1'b0;
  logic [ADDR_W-1:0]    adr  = 8'h00;
  logic [3:0]           sel  = 4'h0;
  logic [DATA_W-1:0]    wdat = DATA_ZERO, rdat;
  logic [NUM_UNITS-1:0] hit  = 4'h0, en;
  logic                 ack, evt_in, evt_out, halt, irq;
  logic [63:0]          notes[$];
  logic [63:0]          note;
  int                   bad_count = 0, compares = 0, halts = 0, lows = 0, h0, l0;
  int                   seed = 32'h0619_7407;

  edp_top edp_top_inst
  (
    .mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_event_in_i(evt_in),
    .debug_mode_i(dbg), .unit_hit_i(hit), .ext_event_out_o(evt_out), .halt_req_o(halt), .irq_o(irq)
  );

  edp_equip edp_equip_inst (.mclk_i(mclk_i), .fire_i(fire), .ext_event_in_o(evt_in));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one classic cycle; a read leaves its expected value and mask as a note
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    int n;
    n = 0;
    @(posedge mclk_i);
    if (!w)
      notes.push_back({m, d});
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hf;
    wdat <= d;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (n >= 20)
      bad_count++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic end_sim;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  initial forever #5 mclk_i = ~mclk_i;

  // the whole run needs well under a tenth of this span
  initial
  begin
    #200000;
    bad_count++;
    end_sim();
  end

  // count pulses, and compare each read answer with the oldest note
  always @(posedge mclk_i)
  begin
    if (halt === 1'b1)
      halts++;
    if (evt_out === 1'b0)
      lows++;
    if (ack === 1'b1 && we === 1'b0)
    begin
      if (notes.size() == 0)
        bad_count++;
      else
      begin
        // take the note first so argument order cannot pair data with the wrong mask
        note = notes.pop_front();
        check("read data", rdat & note[63:32], note[31:0]);
      end
    end
  end

  initial
  begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    // the five words 0x00 to 0x10 zero after reset, the hole at 0x0c included
    for (int i = 0; i < 5; i++)
      wb(1'b0, 8'(i * 4), DATA_ZERO, 32'hffff_ffff);
    wb(1'b1, ADDR_MASK, 32'h0000_0001, DATA_ZERO);
    // every input control code; only 01 halts, flags and interrupts
    for (int c = 0; c < 4; c++)
    begin
      wb(1'b1, ADDR_CTRL, 32'(c), DATA_ZERO);
      h0 = halts;
      fire <= 1'b1;
      @(posedge mclk_i);
      fire <= 1'b0;
      repeat (8) @(posedge mclk_i);
      check("halt pulses", 32'(halts - h0), 32'(c == 1));
      check("irq", {31'h0, irq}, 32'(c == 1));
      wb(1'b0, ADDR_STATUS, 32'(c == 1), 32'h0000_0001);
    end
    repeat (2) @(posedge mclk_i);
    check("irq after read", {31'h0, irq}, DATA_ZERO);
    // debug entry: silent with select 00, one low cycle with 01
    for (int s = 0; s < 2; s++)
    begin
      wb(1'b1, ADDR_CTRL, 32'(s << 2), DATA_ZERO);
      l0 = lows;
      dbg <= 1'b1;
      repeat (4) @(posedge mclk_i);
      dbg <= 1'b0;
      repeat (2) @(posedge mclk_i);
      check("entry low cycles", 32'(lows - l0), 32'(s));
    end
    // both entries leave only the entry-seen status bit set
    wb(1'b0, ADDR_STATUS, 32'h0000_0002, 32'h0000_0007);
    // random hits against random enables, shown only with select 10
    for (int k = 0; k < 12; k++)
    begin
      en = 4'($random(seed));
      for (int u = 0; u < NUM_UNITS; u++)
        wb(1'b1, ADDR_UNIT0 + 8'(u * 4), {31'h0, en[u]}, DATA_ZERO);
      wb(1'b1, ADDR_CTRL, (k < 8) ? 32'h0000_0008 : ((k < 10) ? 32'h0000_0004 : 32'h0000_000c), DATA_ZERO);
      hit <= 4'($random(seed));
      repeat (3) @(posedge mclk_i);
      check("event out", {31'h0, evt_out}, {31'h0, (k < 8) ? ~|(hit & en) : 1'b1});
    end
    end_sim();
  end
endmodule : ext_debug_event_pins_bench
